// ===== include/fsp_pkg.sv
// Constants, register map and state types for the flash self-program sequencer.
// Assumes a 25 MHz system clock and a simple strobe register port.
// Function
// (R1) Programming writes one row per operation and erasure clears a whole eight-row page.
// (R2) Software copies the eight-row page to RAM, merges new data and writes it all back after erase.
// (R3) Operation select value 0010 in control bits 3..0 chooses page erase.
// (R4) Operation select value 0001 chooses row program, which needs erase clear and enable set.
// (R5) Control bit 6 is the erase flag and bit 14 the program enable; both arm a page erase.
// (R6) Software loads the page start address into the table page pointer before erasing.
// (R7) Software writes 0x55 then 0xAA to the unlock key port right before the launch.
// (R8) No erase or program starts unless the unlock key pair was written.
// (R9) Setting control bit 15 launches the armed erase or row program.
// (R10) The CPU is stalled for the whole erase or program cycle.
// (R11) Hardware clears the launch bit when the cycle completes.
// (R12) Software loads 64 instructions into the write buffers before each row program.
// (R13) Software repeats loading and programming, stepping the table page, for every row.
// (R14) Software places two no-ops after the launch and waits for the programming time.
// (R15) A launch without program enable or a valid unlock does no flash operation.
package fsp_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  // Register addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_KEY = 4'h1;
  localparam logic [3:0] ADDR_PAGE = 4'h2;
  localparam logic [3:0] ADDR_OFFS = 4'h3;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  // Control fields
  localparam int unsigned OP_LSB = 0;
  localparam int unsigned ERASE_BIT = 6;
  localparam int unsigned PROGRAM_ENABLE_BIT_BIT = 14;
  localparam int unsigned LAUNCH_BIT = 15;
  localparam logic [3:0] OP_ERASE = 4'h2;
  localparam logic [3:0] OP_ROW = 4'h1;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h404f;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Geometry
  localparam int unsigned ROWS_PER_PAGE = 8;
  localparam int unsigned WORDS_PER_ROW = 64;
  // Operation times in microseconds, with derived cycle counts
  localparam int unsigned ERASE_TIME_US = 20000;
  localparam int unsigned ROW_TIME_US = 1600;
  localparam int unsigned ERASE_CYC = ERASE_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned ROW_CYC = ROW_TIME_US * (CLK_HZ / 1000000);

  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_ERASE = 2'b01,
    FSP_ROW = 2'b10,
    FSP_DONE = 2'b11
  } fsp_state_t;

  typedef enum logic [1:0] {
    FSP_KEY_NONE = 2'b00,
    FSP_KEY_HALF = 2'b01,
    FSP_KEY_OPEN = 2'b10
  } fsp_key_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } fsp_bus_req_t;

  typedef struct packed {
    logic erase_go;
    logic row_go;
    logic [7:0] page;
    logic [15:0] offs;
  } fsp_flash_cmd_t;
endpackage : fsp_pkg

// ===== rtl/fsp_timer.sv
// Down-counter that times one flash erase or row program.
// Assumes a start pulse only while it is idle.
`timescale 1ns/1ps
module fsp_timer #(
  parameter int unsigned CNT_W = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic [CNT_W-1:0] load,
  output logic done
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic run;
    logic done;
  } fsp_tmr_st_t;

  fsp_tmr_st_t st_q;
  fsp_tmr_st_t st_d;

  initial begin
    if (CNT_W < 2) $error("fsp_timer: CNT_W too small");
  end

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (start && !st_q.run) begin
      st_d.cnt = load;
      st_d.run = 1'b1;
    end else if (st_q.run) begin
      if (st_q.cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
        st_d.run = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign done = st_q.done;
endmodule : fsp_timer

// ===== rtl/fsp_sequencer.sv
// Flash self-program sequencer: control register, unlock keys, stall and timing.
// Assumes a one-cycle strobe register port and a flash array that acts on command pulses.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module fsp_sequencer #(
  parameter int unsigned ERASE_CYCLES = fsp_pkg::ERASE_CYC,
  parameter int unsigned ROW_CYCLES = fsp_pkg::ROW_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [fsp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fsp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [fsp_pkg::DATA_W-1:0] reg_rdata,
  // CPU
  output logic cpu_stall,
  // Flash array
  output logic flash_erase_go,
  output logic flash_row_go,
  output logic [7:0] flash_page,
  output logic [15:0] flash_offs,
  output logic flash_busy
);
  localparam int unsigned CNT_W = 20;

  typedef struct packed {
    logic [15:0] ctrl;
    fsp_pkg::fsp_key_t key;
    fsp_pkg::fsp_state_t state;
    logic [7:0] page;
    logic [15:0] offs;
    logic [15:0] rdata;
    logic stall;
    logic erase_go;
    logic row_go;
    logic refused;
    logic tmr_start;
    logic [CNT_W-1:0] tmr_load;
  } fsp_st_t;

  fsp_st_t st_q;
  fsp_st_t st_d;
  logic tmr_done;
  logic [15:0] wr_ctrl;
  logic arm_erase;
  logic arm_row;

  initial begin
    if (ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << CNT_W)) $error("ERASE_CYCLES out of range");
    if (ROW_CYCLES < 1 || ROW_CYCLES >= (1 << CNT_W)) $error("ROW_CYCLES out of range");
  end

  fsp_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(st_q.tmr_start),
    .load(st_q.tmr_load),
    .done(tmr_done)
  );

  // Launch bit is not stored by the write mask; it is set only by an accepted start
  assign wr_ctrl = reg_wdata & fsp_pkg::CTRL_WMASK;
  assign arm_erase = (wr_ctrl[3:0] == fsp_pkg::OP_ERASE) // R3
    && wr_ctrl[fsp_pkg::ERASE_BIT] && wr_ctrl[fsp_pkg::PROGRAM_ENABLE_BIT_BIT]; // R5
  assign arm_row = (wr_ctrl[3:0] == fsp_pkg::OP_ROW) // R4
    && !wr_ctrl[fsp_pkg::ERASE_BIT] && wr_ctrl[fsp_pkg::PROGRAM_ENABLE_BIT_BIT]; // R4

  always_comb begin
    st_d = st_q;
    st_d.erase_go = 1'b0;
    st_d.row_go = 1'b0;
    st_d.tmr_start = 1'b0;
    st_d.rdata = '0;

    if (reg_rd) begin
      case (reg_addr)
        fsp_pkg::ADDR_CTRL: st_d.rdata = st_q.ctrl;
        fsp_pkg::ADDR_PAGE: st_d.rdata = {8'h00, st_q.page};
        fsp_pkg::ADDR_OFFS: st_d.rdata = st_q.offs;
        fsp_pkg::ADDR_STAT: st_d.rdata = {13'h0000, st_q.refused,
          (st_q.key == fsp_pkg::FSP_KEY_OPEN), (st_q.state != fsp_pkg::FSP_IDLE)};
        default: st_d.rdata = '0;
      endcase
    end

    case (st_q.state)
      fsp_pkg::FSP_IDLE: begin
        if (reg_wr) begin
          case (reg_addr)
            fsp_pkg::ADDR_KEY: begin
              // Any write other than the ordered pair drops the unlock
              if (reg_wdata[7:0] == fsp_pkg::KEY_FIRST) begin
                st_d.key = fsp_pkg::FSP_KEY_HALF; // R7
              end else if (reg_wdata[7:0] == fsp_pkg::KEY_SECOND
                           && st_q.key == fsp_pkg::FSP_KEY_HALF) begin
                st_d.key = fsp_pkg::FSP_KEY_OPEN; // R7
              end else begin
                st_d.key = fsp_pkg::FSP_KEY_NONE;
              end
            end
            fsp_pkg::ADDR_PAGE: begin
              st_d.page = reg_wdata[7:0];
              st_d.key = fsp_pkg::FSP_KEY_NONE;
            end
            fsp_pkg::ADDR_OFFS: begin
              st_d.offs = reg_wdata;
              st_d.key = fsp_pkg::FSP_KEY_NONE;
            end
            fsp_pkg::ADDR_CTRL: begin
              st_d.ctrl = wr_ctrl;
              st_d.key = fsp_pkg::FSP_KEY_NONE;
              if (reg_wdata[fsp_pkg::LAUNCH_BIT]) begin // R9
                if (st_q.key == fsp_pkg::FSP_KEY_OPEN && (arm_erase || arm_row)) begin // R8
                  st_d.ctrl[fsp_pkg::LAUNCH_BIT] = 1'b1;
                  st_d.stall = 1'b1; // R10
                  st_d.tmr_start = 1'b1;
                  st_d.refused = 1'b0;
                  if (arm_erase) begin
                    st_d.state = fsp_pkg::FSP_ERASE;
                    st_d.erase_go = 1'b1; // R1
                    st_d.tmr_load = CNT_W'(ERASE_CYCLES);
                  end else begin
                    st_d.state = fsp_pkg::FSP_ROW;
                    st_d.row_go = 1'b1; // R1
                    st_d.tmr_load = CNT_W'(ROW_CYCLES);
                  end
                end else begin
                  st_d.refused = 1'b1; // R15
                end
              end
            end
            default: st_d.key = fsp_pkg::FSP_KEY_NONE;
          endcase
        end
      end
      fsp_pkg::FSP_ERASE, fsp_pkg::FSP_ROW: begin
        // Writes are ignored while the CPU is stalled
        if (tmr_done) begin
          st_d.state = fsp_pkg::FSP_DONE;
        end
      end
      fsp_pkg::FSP_DONE: begin
        st_d.ctrl[fsp_pkg::LAUNCH_BIT] = 1'b0; // R11
        st_d.stall = 1'b0; // R10
        st_d.state = fsp_pkg::FSP_IDLE;
      end
      default: st_d.state = fsp_pkg::FSP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign cpu_stall = st_q.stall;
  assign flash_erase_go = st_q.erase_go;
  assign flash_row_go = st_q.row_go;
  assign flash_page = st_q.page;
  assign flash_offs = st_q.offs;
  assign flash_busy = st_q.stall;
endmodule : fsp_sequencer

// ===== testbench/fsp_flash_model.sv
// Behavioural program flash array behind the sequencer.
// Assumes one-cycle erase and row command pulses.
`timescale 1ns/1ps
module fsp_flash_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Commands
  input wire logic erase_go,
  input wire logic row_go,
  input wire logic [7:0] page,
  // Observed counts
  output logic [7:0] n_erase,
  output logic [7:0] n_row,
  output logic [7:0] last_page,
  output logic bad
);
  logic [7:0] rows_left;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_erase <= 8'h00;
      n_row <= 8'h00;
      last_page <= 8'h00;
      rows_left <= 8'h00;
      bad <= 1'b0;
    end else if (erase_go) begin
      n_erase <= n_erase + 8'h01;
      last_page <= page;
      rows_left <= 8'h08;
    end else if (row_go) begin
      n_row <= n_row + 8'h01;
      // At most eight row programs are allowed after each page erase
      if (rows_left == 8'h00) bad <= 1'b1;
      else rows_left <= rows_left - 8'h01;
    end
  end
endmodule : fsp_flash_model

// ===== testbench/fsp_sequencer_sva.sv
// Port checker for the flash self-program sequencer.
// Assumes no register writes while the sequencer is busy.
`timescale 1ns/1ps
module fsp_sequencer_sva #(
  parameter int unsigned ERASE_CYCLES = 5,
  parameter int unsigned ROW_CYCLES = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Outputs
  input wire logic cpu_stall,
  input wire logic flash_erase_go,
  input wire logic flash_row_go,
  input wire logic [7:0] flash_page,
  input wire logic [15:0] flash_offs,
  input wire logic flash_busy
);
  localparam int EW = ERASE_CYCLES - 1;
  localparam int RW = ROW_CYCLES - 1;
  logic [1:0] key_q;
  logic [1:0] key_d;
  logic ctrl_wr;
  logic key_wr;
  assign ctrl_wr = reg_wr && reg_addr == fsp_pkg::ADDR_CTRL;
  assign key_wr = reg_wr && reg_addr == fsp_pkg::ADDR_KEY;
  always_comb begin
    key_d = key_q;
    if (reg_wr && !flash_busy) begin
      key_d = 2'd0;
      if (key_wr && reg_wdata[7:0] == 8'h55) key_d = 2'd1;
      if (key_wr && reg_wdata[7:0] == 8'haa && key_q == 2'd1) key_d = 2'd2;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) key_q <= 2'd0;
    else key_q <= key_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_go_excl; !(flash_erase_go && flash_row_go); endproperty
  property p_erase_arm; flash_erase_go |-> $past(ctrl_wr && reg_wdata[15:14] == 2'b11
    && reg_wdata[6] && reg_wdata[3:0] == fsp_pkg::OP_ERASE); endproperty
  property p_row_arm; flash_row_go |-> $past(ctrl_wr && reg_wdata[15:14] == 2'b11
    && !reg_wdata[6] && reg_wdata[3:0] == fsp_pkg::OP_ROW); endproperty
  property p_unlock; flash_erase_go || flash_row_go |-> $past(key_q) == 2'd2; endproperty
  property p_stall_rise; $rose(cpu_stall) |-> flash_erase_go || flash_row_go; endproperty
  property p_erase_len;
    flash_erase_go |-> (cpu_stall throughout ##EW 1'b1) ##[1:4] !cpu_stall;
  endproperty
  property p_row_len;
    flash_row_go |-> (cpu_stall throughout ##RW 1'b1) ##[1:4] !cpu_stall;
  endproperty
  property p_busy; flash_busy == cpu_stall; endproperty
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_go_excl: assert property (p_go_excl) else $error("two commands at once");
  a_erase_arm: assert property (p_erase_arm) else $error("erase not armed");
  a_row_arm: assert property (p_row_arm) else $error("row not armed");
  a_unlock: assert property (p_unlock) else $error("command without keys");
  a_stall_rise: assert property (p_stall_rise) else $error("stray stall");
  a_erase_len: assert property (p_erase_len) else $error("erase stall length");
  a_row_len: assert property (p_row_len) else $error("row stall length");
  a_busy: assert property (p_busy) else $error("busy differs from stall");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  c_erase: cover property (flash_erase_go);
  c_row: cover property (flash_row_go);
  c_refuse: cover property (ctrl_wr && reg_wdata[15] && key_q != 2'd2);
endmodule : fsp_sequencer_sva
bind fsp_sequencer fsp_sequencer_sva #(.ERASE_CYCLES(ERASE_CYCLES), .ROW_CYCLES(ROW_CYCLES))
  u_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall),
  .flash_erase_go(flash_erase_go), .flash_row_go(flash_row_go), .flash_page(flash_page),
  .flash_offs(flash_offs), .flash_busy(flash_busy));

// ===== testbench/fsp_sequencer_test.sv
// Self-checking bench for the flash self-program sequencer.
// Assumes short erase and row times set through parameters.
`timescale 1ns/1ps
module fsp_sequencer_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, offs;
  logic cpu_stall, erase_go, row_go, busy, bad;
  logic [7:0] page, n_erase, n_row, last_page;
  int fails = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  fsp_sequencer #(.ERASE_CYCLES(5), .ROW_CYCLES(3)) dut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .flash_erase_go(erase_go),
    .flash_row_go(row_go), .flash_page(page), .flash_offs(offs), .flash_busy(busy));
  fsp_flash_model model (.clk(clk), .rst_n(rst_n), .erase_go(erase_go), .row_go(row_go),
    .page(page), .n_erase(n_erase), .n_row(n_row), .last_page(last_page), .bad(bad));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  // Keys and launch back to back, then wait out the stall
  task automatic launch(input logic [15:0] c, input logic [15:0] stat);
    int n;
    n = 0;
    wr(fsp_pkg::ADDR_KEY, 16'h0055);
    wr(fsp_pkg::ADDR_KEY, 16'h00aa);
    wr(fsp_pkg::ADDR_CTRL, c);
    reg_wr <= 1'b0;
    @(posedge clk);
    #1;
    while (cpu_stall !== 1'b0 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 40) fails++;
    repeat (2) @(posedge clk);
    rd(fsp_pkg::ADDR_STAT, stat);
  endtask : launch
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(fsp_pkg::ADDR_CTRL, 16'h0000);
    rd(fsp_pkg::ADDR_KEY, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(fsp_pkg::ADDR_CTRL, 16'hc042);
    rd(fsp_pkg::ADDR_STAT, 16'h0004);
    wr(fsp_pkg::ADDR_KEY, 16'h0055);
    wr(fsp_pkg::ADDR_PAGE, 16'h0012);
    wr(fsp_pkg::ADDR_KEY, 16'h00aa);
    wr(fsp_pkg::ADDR_CTRL, 16'hc042);
    rd(fsp_pkg::ADDR_STAT, 16'h0004);
    launch(16'h8042, 16'h0004);
    launch(16'hc041, 16'h0004);
    launch(16'hc042, 16'h0000);
    rd(fsp_pkg::ADDR_CTRL, 16'h4042);
    chk({8'h00, last_page}, 16'h0012);
    for (int r = 0; r < 8; r++) begin
      wr(fsp_pkg::ADDR_OFFS, 16'h0400 + 16'(r * 128));
      launch(16'hc001, 16'h0000);
    end
    rd(fsp_pkg::ADDR_CTRL, 16'h4001);
    rd(fsp_pkg::ADDR_PAGE, 16'h0012);
    rd(fsp_pkg::ADDR_OFFS, 16'h0780);
    chk({8'h00, page}, 16'h0012);
    chk(offs, 16'h0780);
    wr(fsp_pkg::ADDR_KEY, 16'h0055);
    wr(fsp_pkg::ADDR_KEY, 16'h00aa);
    rd(fsp_pkg::ADDR_STAT, 16'h0002);
    wr(fsp_pkg::ADDR_CTRL, 16'h4001);
    rd(fsp_pkg::ADDR_STAT, 16'h0000);
    chk({8'h00, n_erase}, 16'h0001);
    chk({8'h00, n_row}, 16'h0008);
    chk({15'h0000, bad}, 16'h0000);
    final_report();
  end
  initial begin
    #400000;
    fails++;
    final_report();
  end
endmodule : fsp_sequencer_test
